// ===== hw/sfrc_pkg.sv
package sfrc_pkg;

	// Register byte offsets on the APB.
	localparam logic [7:0] SFRC_CSR_OFF = 8'h00;
	localparam logic [7:0] SFRC_IRQ_STATUS_OFF = 8'h04;
	localparam logic [7:0] SFRC_IRQ_MASK_OFF = 8'h08;
	localparam logic [7:0] SFRC_RES_OFF = 8'h0c;
	localparam logic [7:0] SFRC_UFCNT_OFF = 8'h10;

	// Fields of the control/status register.
	localparam int SFRC_RC_LSB = 0;
	localparam int SFRC_FTZ_BIT = 2;
	localparam int SFRC_UM_BIT = 3;
	localparam int SFRC_PE_BIT = 4;
	localparam int SFRC_UE_BIT = 5;
	localparam logic [31:0] SFRC_CSR_RESET = 32'h0000_0008;
	localparam logic [31:0] SFRC_CSR_WMASK = 32'h0000_003f;

	// Interrupt status bits.
	localparam int SFRC_IRQ_UFEXC = 0;
	localparam int SFRC_IRQ_FLUSH = 1;
	localparam int SFRC_IRQ_W = 2;

	// Operand format: single precision.
	localparam int SFRC_EXP_W = 8;
	localparam int SFRC_MAN_W = 23;
	localparam int SFRC_EXP_BIAS = 127;

	// Rounding modes as held in the control/status register.
	typedef enum logic [1:0] {
		SFRC_RN = 2'h0,
		SFRC_RD = 2'h1,
		SFRC_RU = 2'h2,
		SFRC_RZ = 2'h3
	} sfrc_rmode_t;

	// Opcode classes seen by this stage.
	typedef enum logic [1:0] {
		SFRC_OP_ARITH = 2'h0,
		SFRC_OP_PACKED_TRUNC = 2'h1,
		SFRC_OP_SCALAR_TRUNC = 2'h2,
		SFRC_OP_CONVERT = 2'h3
	} sfrc_op_t;

endpackage

// ===== hw/sfrc_cond_if.sv
`timescale 1ns/1ns
interface sfrc_cond_if;
	import sfrc_pkg::*;
	logic [1:0] rmode;
	logic ftz;
	logic um;
	logic sign;
	logic signed [11:0] exp;
	logic [26:0] man;
	logic [31:0] result;
	logic underflow;
	logic flushed;
	logic inexact;
	logic exc;
	modport ctl (output rmode, output ftz, output um, output sign, output exp, output man,
		input result, input underflow, input flushed, input inexact, input exc);
	modport dp (input rmode, input ftz, input um, input sign, input exp, input man,
		output result, output underflow, output flushed, output inexact, output exc);
endinterface

// ===== hw/sfrc_round.sv
`timescale 1ns/1ns
module sfrc_round
	import sfrc_pkg::*;
(
	// Control side.
	sfrc_cond_if.dp cond
);

	logic signed [11:0] shift;
	logic [26:0] sh;
	logic sticky;
	logic lsb;
	logic grd;
	logic rest;
	logic up;
	logic [24:0] rnd;
	logic [11:0] e;
	logic tiny;

	// Align a tiny value to the denormal scale, then round with guard and sticky.
	always_comb
	begin
		e = cond.exp;
		tiny = (cond.exp < 12'sd1);
		shift = tiny ? (12'sd1 - cond.exp) : 12'sd0;
		sh = cond.man;
		sticky = 1'b0;
		for (int i = 0; i < 27; i++)
			if (i < shift)
			begin
				sticky = sticky | sh[0];
				sh = {1'b0, sh[26:1]};
			end
		lsb = sh[3];
		grd = sh[2];
		rest = sh[1] | sh[0] | sticky;
		case (sfrc_rmode_t'(cond.rmode))
			SFRC_RN: up = grd & (rest | lsb);
			SFRC_RD: up = cond.sign & (grd | rest);
			SFRC_RU: up = ~cond.sign & (grd | rest);
			default: up = 1'b0;
		endcase
		rnd = {1'b0, sh[26:3]} + {24'h0, up};
		cond.inexact = grd | rest;
		// Underflow in flush mode is the exponent alone; otherwise tininess with loss.
		cond.underflow = cond.ftz ? tiny : (tiny & (grd | rest));
		cond.exc = cond.underflow & ~cond.um;
		cond.flushed = cond.ftz & tiny & cond.um;
		if (cond.flushed)
			cond.result = {cond.sign, 31'h0};
		else if (tiny)
			// A carry out of the denormal fraction lands in the exponent and gives the smallest normal.
			cond.result = {cond.sign, 7'h0, rnd[23], rnd[22:0]};
		else
			cond.result = {cond.sign, e[7:0] + {7'h0, rnd[24]}, rnd[22:0]};
	end

endmodule

// ===== hw/sfrc_top.sv
`timescale 1ns/1ns
// Behaviour
// - Truncating convert opcodes always round toward zero regardless of the programmed mode.
// - A flushed underflow with underflow masked sets both precision and underflow flags.
// - A flushed underflow with underflow masked returns zero instead of a denormal.
// - Without flush-to-zero a masked underflow returns the correctly denormalised result.
// - In flush-to-zero mode underflow is any result exponent in the denormal range.
// - An unmasked underflow raises an exception instead of flushing.
module sfrc_top
	import sfrc_pkg::*;
(
	// APB slave.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Operation request from the datapath.
	input wire logic op_valid,
	input wire logic [1:0] op_kind,
	input wire logic op_sign,
	input wire logic signed [11:0] op_exp,
	input wire logic [26:0] op_man,
	// Conditioned result.
	output logic res_valid,
	output logic [31:0] res_data,
	output logic res_exc,
	// Interrupt.
	output logic irq
);

	sfrc_cond_if cond ();

	logic [31:0] csr_r, csr_nxt;
	logic [SFRC_IRQ_W-1:0] ists_r, ists_nxt;
	logic [SFRC_IRQ_W-1:0] imask_r, imask_nxt;
	logic [31:0] ufcnt_r, ufcnt_nxt;
	logic [31:0] res_r, res_nxt;
	logic rv_r, rv_nxt;
	logic rx_r, rx_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic pready_r, pready_nxt;
	logic pslverr_r, pslverr_nxt;
	logic irq_r, irq_nxt;
	logic wr_acc;
	logic rd_acc;
	logic [SFRC_IRQ_W-1:0] ev;

	// True for a byte offset this block decodes.
	function automatic logic sfrc_mapped(input logic [7:0] a);
		return (a == SFRC_CSR_OFF) || (a == SFRC_IRQ_STATUS_OFF) || (a == SFRC_IRQ_MASK_OFF)
			|| (a == SFRC_RES_OFF) || (a == SFRC_UFCNT_OFF);
	endfunction

	// The access is decoded in its first cycle; pready is registered, so one wait state.
	assign wr_acc = psel & penable & pwrite & ~pready_r;
	assign rd_acc = psel & penable & ~pwrite & ~pready_r;

	// Rounding mode selection and operand hand-off to the conditioning datapath.
	always_comb
	begin
		if ((op_kind == SFRC_OP_PACKED_TRUNC) || (op_kind == SFRC_OP_SCALAR_TRUNC))
			cond.rmode = SFRC_RZ;
		else
			cond.rmode = csr_r[SFRC_RC_LSB +: 2];
		cond.ftz = csr_r[SFRC_FTZ_BIT];
		cond.um = csr_r[SFRC_UM_BIT];
		cond.sign = op_sign;
		cond.exp = op_exp;
		cond.man = op_man;
	end

	sfrc_round u_round (
		.cond(cond)
	);

	// Events that feed the sticky interrupt status.
	always_comb
	begin
		ev = '0;
		ev[SFRC_IRQ_UFEXC] = op_valid & cond.exc;
		ev[SFRC_IRQ_FLUSH] = op_valid & cond.flushed;
	end

	// Register file, flags, result capture and bus answer.
	always_comb
	begin
		csr_nxt = csr_r;
		ists_nxt = ists_r;
		imask_nxt = imask_r;
		ufcnt_nxt = ufcnt_r;
		res_nxt = res_r;
		rv_nxt = op_valid & ~cond.exc;
		rx_nxt = op_valid & cond.exc;
		prdata_nxt = 32'h0;
		pready_nxt = psel & penable & ~pready_r;
		pslverr_nxt = 1'b0;
		if (wr_acc)
		begin
			pslverr_nxt = ~sfrc_mapped(paddr);
			case (paddr)
				SFRC_CSR_OFF: csr_nxt = pwdata & SFRC_CSR_WMASK;
				SFRC_IRQ_STATUS_OFF: ists_nxt = ists_r & ~pwdata[SFRC_IRQ_W-1:0];
				SFRC_IRQ_MASK_OFF: imask_nxt = pwdata[SFRC_IRQ_W-1:0];
				SFRC_UFCNT_OFF: ufcnt_nxt = 32'h0;
				default: ;
			endcase
		end
		if (rd_acc)
		begin
			pslverr_nxt = ~sfrc_mapped(paddr);
			case (paddr)
				SFRC_CSR_OFF: prdata_nxt = csr_r;
				SFRC_IRQ_STATUS_OFF: prdata_nxt = {30'h0, ists_r};
				SFRC_IRQ_MASK_OFF: prdata_nxt = {30'h0, imask_r};
				SFRC_RES_OFF: prdata_nxt = res_r;
				SFRC_UFCNT_OFF: prdata_nxt = ufcnt_r;
				default: prdata_nxt = 32'h0;
			endcase
		end
		// Hardware flag setting is applied last so that it beats a same-cycle software clear.
		if (op_valid)
		begin
			if (cond.flushed)
			begin
				csr_nxt[SFRC_PE_BIT] = 1'b1;
				csr_nxt[SFRC_UE_BIT] = 1'b1;
			end
			else if (cond.underflow & cond.um)
			begin
				csr_nxt[SFRC_UE_BIT] = 1'b1;
				csr_nxt[SFRC_PE_BIT] = csr_nxt[SFRC_PE_BIT] | cond.inexact;
			end
			else if (cond.inexact & ~cond.exc)
				csr_nxt[SFRC_PE_BIT] = 1'b1;
			if (cond.underflow)
				ufcnt_nxt = ufcnt_r + 32'h1;
			if (~cond.exc)
				res_nxt = cond.result;
		end
		ists_nxt = ists_nxt | ev;
		irq_nxt = |(ists_nxt & imask_nxt);
	end

	// State registers.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			csr_r <= SFRC_CSR_RESET;
			ists_r <= '0;
			imask_r <= '0;
			ufcnt_r <= 32'h0;
			res_r <= 32'h0;
			rv_r <= 1'b0;
			rx_r <= 1'b0;
			prdata_r <= 32'h0;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			irq_r <= 1'b0;
		end
		else
		begin
			csr_r <= csr_nxt;
			ists_r <= ists_nxt;
			imask_r <= imask_nxt;
			ufcnt_r <= ufcnt_nxt;
			res_r <= res_nxt;
			rv_r <= rv_nxt;
			rx_r <= rx_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			irq_r <= irq_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign res_valid = rv_r;
	assign res_data = res_r;
	assign res_exc = rx_r;
	assign irq = irq_r;

endmodule

// ===== verif/sfrc_chk.sv
`timescale 1ns/1ns
module sfrc_chk
	import sfrc_pkg::*;
(
	// Clock, reset and bus.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	// Operation and result.
	input wire logic op_valid,
	input wire logic [1:0] op_kind,
	input wire logic op_sign,
	input wire logic signed [11:0] op_exp,
	input wire logic [26:0] op_man,
	input wire logic res_valid,
	input wire logic [31:0] res_data,
	input wire logic res_exc
);
	logic csr_wr, ftz_r, ftz_nxt, um_r, um_nxt;
	// The mode bits are shadowed here because the register is not visible at the ports.
	assign csr_wr = psel && penable && pready && pwrite && paddr == SFRC_CSR_OFF;
	assign ftz_nxt = csr_wr ? pwdata[SFRC_FTZ_BIT] : ftz_r;
	assign um_nxt = csr_wr ? pwdata[SFRC_UM_BIT] : um_r;
	// Shadow registers follow each completed write to the control/status register.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ftz_r <= SFRC_CSR_RESET[SFRC_FTZ_BIT];
			um_r <= SFRC_CSR_RESET[SFRC_UM_BIT];
		end
		else
		begin
			ftz_r <= ftz_nxt;
			um_r <= um_nxt;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_op_answered: assert property (op_valid |=> res_valid ^ res_exc)
		else $error("Operation not answered once.");
	a_res_cause: assert property (res_valid || res_exc |-> $past(op_valid))
		else $error("Result without operation.");
	a_wait_state: assert property (psel && penable && !pready |=> pready)
		else $error("Bus answer late.");
	a_pready_pulse: assert property (pready |=> !pready)
		else $error("Bus answer held.");
	a_slverr_map: assert property (pready |-> pslverr == (paddr > SFRC_UFCNT_OFF || paddr[1:0] != 2'h0))
		else $error("Bus error flag wrong.");
	a_trunc_zero: assert property (op_valid && op_kind inside {SFRC_OP_PACKED_TRUNC, SFRC_OP_SCALAR_TRUNC}
		&& op_exp > 0 && op_exp < 255 |=> res_valid && res_data[22:0] == $past(op_man[25:3]))
		else $error("Truncating convert rounded.");
	a_flush_zero: assert property (op_valid && ftz_r && um_r && op_exp < 1
		|=> res_valid && res_data == {$past(op_sign), 31'h0})
		else $error("Flush result wrong.");
	a_gradual_uf: assert property (op_valid && !ftz_r && um_r && op_exp == 0 && op_man[3:0] == 4'h0
		|=> res_valid && res_data == {$past(op_sign), 8'h0, $past(op_man[26:4])})
		else $error("Denormal result wrong.");
	a_unmasked_exc: assert property (op_valid && ftz_r && !um_r && op_exp < 1 |=> res_exc && !res_valid)
		else $error("Exception not taken.");
endmodule

// ===== verif/tb_top.sv
`timescale 1ns/1ns
module tb_top
	import sfrc_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, op_valid, op_sign, pready, pslverr, res_valid, res_exc, irq, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, res_data, q;
	logic [1:0] op_kind;
	logic signed [11:0] op_exp;
	logic [26:0] op_man;
	int failures, num_checks, cyc;
	sfrc_top i_sfrc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .op_valid(op_valid),
		.op_kind(op_kind), .op_sign(op_sign), .op_exp(op_exp), .op_man(op_man), .res_valid(res_valid),
		.res_data(res_data), .res_exc(res_exc), .irq(irq));
	task automatic close_out;
		if (failures == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	// One bus transfer; the request is held until the answer edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// One operation pulse; results are looked at once the answer edge has settled.
	task automatic op(input logic [1:0] k, input logic s, input logic signed [11:0] x, input logic [26:0] m);
		@(posedge pclk);
		op_valid <= 1'b1;
		op_kind <= k;
		op_sign <= s;
		op_exp <= x;
		op_man <= m;
		@(posedge pclk);
		op_valid <= 1'b0;
		#1;
	endtask
	// Clock of 100 ns period.
	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	// A hang is cut short well above the expected run length.
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			failures++;
			$display("Error at %0t: run did not finish in time", $time);
			close_out;
		end
	end
	// Main sequence.
	initial
	begin
		{psel, penable, pwrite, op_valid, op_kind, op_sign, paddr, pwdata, op_exp, op_man} = '0;
		presetn = 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, SFRC_CSR_OFF, 0);
		check(q, SFRC_CSR_RESET);
		apb(0, 8'h20, 0);
		check({31'h0, err}, 32'h1);
		check(q, 32'h0);
		apb(1, SFRC_CSR_OFF, 32'hc);
		op(0, 1, 0, 27'h400_0000);
		check({res_exc, res_valid}, 32'h1);
		check(res_data, 32'h8000_0000);
		apb(0, SFRC_CSR_OFF, 0);
		check(q, 32'h3c);
		apb(0, SFRC_IRQ_STATUS_OFF, 0);
		check(q, 32'h2);
		apb(1, SFRC_IRQ_STATUS_OFF, 32'h2);
		apb(1, SFRC_CSR_OFF, 32'h8);
		op(0, 0, 0, 27'h400_0000);
		check(res_data, 32'h0040_0000);
		apb(1, SFRC_IRQ_MASK_OFF, 0);
		apb(1, SFRC_CSR_OFF, 32'h4);
		op(3, 1, -1, 27'h400_0000);
		check({res_exc, res_valid}, 32'h2);
		check(res_data, 32'h0040_0000);
		apb(0, SFRC_IRQ_STATUS_OFF, 0);
		check(q, 32'h1);
		check({31'h0, irq}, 32'h0);
		apb(1, SFRC_IRQ_MASK_OFF, 32'h3);
		apb(0, SFRC_IRQ_STATUS_OFF, 0);
		check(q, 32'h1);
		check({31'h0, irq}, 32'h1);
		apb(1, SFRC_IRQ_STATUS_OFF, 32'h1);
		apb(0, SFRC_IRQ_STATUS_OFF, 0);
		check(q, 32'h0);
		check({31'h0, irq}, 32'h0);
		// Two underflows so far; the excepting one left the stored result alone.
		apb(0, SFRC_UFCNT_OFF, 0);
		check(q, 32'h2);
		apb(0, SFRC_RES_OFF, 0);
		check(q, 32'h0040_0000);
		apb(1, SFRC_CSR_OFF, 32'h8);
		// A denormal that rounds up must become the smallest normal number.
		op(0, 0, 0, 27'h7ff_ffff);
		check(res_data, 32'h0080_0000);
		for (int k = 0; k < 4; k++)
		begin
			op(k[1:0], 0, 127, 27'h400_0007);
			check(res_data, (k == 1 || k == 2) ? 32'h3f80_0000 : 32'h3f80_0001);
		end
		// Programmed modes apply to ordinary operations; a negative operand tells down from up.
		for (int m = 1; m < 4; m++)
		begin
			apb(1, SFRC_CSR_OFF, 32'h8 | m);
			op(0, 1, 127, 27'h400_0007);
			check(res_data, (m == 1) ? 32'hbf80_0001 : 32'hbf80_0000);
		end
		close_out;
	end
endmodule
bind sfrc_top sfrc_chk i_sfrc_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .op_valid(op_valid), .op_kind(op_kind),
	.op_sign(op_sign), .op_exp(op_exp), .op_man(op_man), .res_valid(res_valid), .res_data(res_data),
	.res_exc(res_exc));
